// file: enhanced_timer_compare_pwm_tb.sv
`timescale 1ns/1ns
module enhanced_timer_compare_pwm_tb import etcp_pkg::*;;
  // Clock, reset and bus drive
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] PSTRB = 4'hf;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, CHAN_A_OUT_PIN, CHAN_A_OUT_EN, IRQ;
  logic [2:0] CHAN_B_OUT_PIN, CHAN_B_OUT_EN, MATCH_FLAGS;
  int failures = 0;
  int tests_run = 0;
  int ca, cb, cx;
  logic [1:0] fn;
  // Expected high counts per function code
  int exp_a [3] = '{0, 128, 32};

  // Free running clock
  always #2 CLK = ~CLK;

  etcp_timer dut (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CHAN_A_OUT_PIN(CHAN_A_OUT_PIN),
    .CHAN_A_OUT_EN(CHAN_A_OUT_EN), .CHAN_B_OUT_PIN(CHAN_B_OUT_PIN),
    .CHAN_B_OUT_EN(CHAN_B_OUT_EN), .MATCH_FLAGS(MATCH_FLAGS), .IRQ(IRQ));

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20) begin
      @(posedge CLK);
      n++;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // Read and compare data and error response
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check(32'(e), 32'(exp_err));
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic set_ab(input logic [9:0] a, input logic [9:0] b);
    wr(OFS_A_LO, 32'(a[7:0]));
    wr(OFS_A_HI, 32'(a[9:8]));
    wr(OFS_B_LO, 32'(b[7:0]));
    wr(OFS_B_HI, 32'(b[9:8]));
  endtask

  // Bounded wait for one status flag
  task automatic wait_flag(input int idx, input int lim);
    int n;
    n = 0;
    settle(1);
    while (MATCH_FLAGS[idx] !== 1'b1 && n < lim) begin
      settle(1);
      n++;
    end
    check(32'(MATCH_FLAGS[idx]), 32'h1);
  endtask

  // Restart with new setup, let it settle, then count pin high cycles
  task automatic pwm_run(input logic [7:0] c1, input logic [7:0] c2, input logic [9:0] a,
                         input logic [9:0] b, input int n);
    wr(OFS_CTRL0, 32'h01);
    wr(OFS_CTRL1, 32'(c1));
    wr(OFS_CTRL2, 32'(c2));
    set_ab(a, b);
    wr(OFS_STAT, 32'h7);
    wr(OFS_CTRL0, 32'h09);
    settle(300);
    ca = 0;
    cb = 0;
    cx = 0;
    repeat (n) begin
      settle(1);
      ca += int'(CHAN_A_OUT_PIN === 1'b1);
      cb += int'(CHAN_B_OUT_PIN[0] === 1'b1);
      cx += int'(CHAN_A_OUT_PIN === 1'b1 && CHAN_B_OUT_PIN[0] !== 1'b1);
    end
  endtask

  // Report counts and verdict, then stop
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    // Reset values, unused bits and unmapped access
    rdc(OFS_A_HI, 32'h0, 1'b0);
    rdc(OFS_B_LO, 32'h0, 1'b0);
    rdc(OFS_B_HI, 32'h0, 1'b0);
    wr(OFS_A_HI, 32'hff);
    wr(OFS_B_LO, 32'hff);
    wr(OFS_B_HI, 32'hfe);
    rdc(OFS_A_HI, 32'h3, 1'b0);
    rdc(OFS_B_LO, 32'hff, 1'b0);
    rdc(OFS_B_HI, 32'h2, 1'b0);
    // Write with byte lane 0 off changes nothing
    PSTRB <= 4'he;
    wr(OFS_B_LO, 32'h12);
    PSTRB <= 4'hf;
    rdc(OFS_B_LO, 32'hff, 1'b0);
    rdc(8'h30, 32'h0, 1'b1);
    $display("Test registers done");
    // Compare mode: A drives high, B toggles, period clears
    wr(OFS_MASK, 32'h7);
    wr(OFS_CTRL1, 32'h20);
    wr(OFS_CTRL2, 32'h30);
    set_ab(10'd50, 10'd100);
    wr(OFS_CTRL0, 32'h09);
    wait_flag(FLAG_A, 200);
    check(32'(CHAN_B_OUT_PIN), 32'h0);
    wait_flag(FLAG_P, 200);
    check(32'(MATCH_FLAGS), 32'h7);
    check(32'(CHAN_A_OUT_PIN), 32'h1);
    check(32'(CHAN_B_OUT_PIN), 32'h7);
    check(32'(CHAN_A_OUT_EN), 32'h1);
    check(32'(IRQ), 32'h1);
    wr(OFS_CTRL0, 32'h01);
    wr(OFS_STAT, 32'h7);
    rdc(OFS_STAT, 32'h0, 1'b0);
    check(32'(IRQ), 32'h0);
    // Run rising edge restores initial levels
    wr(OFS_CTRL0, 32'h09);
    settle(4);
    check(32'(CHAN_A_OUT_PIN), 32'h0);
    check(32'(CHAN_B_OUT_PIN), 32'h0);
    wr(OFS_CTRL0, 32'h01);
    $display("Test compare done");
    // Clear on A with period below A: no period flag
    wr(OFS_STAT, 32'h7);
    wr(OFS_MASK, 32'h4);
    wr(OFS_CTRL1, 32'h21);
    set_ab(10'd300, 10'd100);
    wr(OFS_CTRL0, 32'h09);
    wait_flag(FLAG_A, 400);
    settle(400);
    check(32'(MATCH_FLAGS), 32'h3);
    check(32'(IRQ), 32'h0);
    wr(OFS_MASK, 32'h1);
    settle(2);
    check(32'(IRQ), 32'h1);
    wr(OFS_CTRL0, 32'h01);
    wr(OFS_STAT, 32'h7);
    $display("Test clear on A done");
    // Timer mode: same flags, pins released
    wr(OFS_CTRL1, 32'hc0);
    wr(OFS_CTRL2, 32'hc0);
    set_ab(10'd50, 10'd100);
    wr(OFS_CTRL0, 32'h09);
    wait_flag(FLAG_P, 400);
    check(32'(MATCH_FLAGS), 32'h7);
    check(32'(CHAN_A_OUT_EN), 32'h0);
    check(32'(CHAN_B_OUT_EN), 32'h0);
    wr(OFS_CTRL0, 32'h01);
    wr(OFS_STAT, 32'h7);
    // Mixed modes give no events
    wr(OFS_CTRL1, 32'h00);
    wr(OFS_CTRL0, 32'h09);
    settle(300);
    check(32'(MATCH_FLAGS), 32'h0);
    check(32'(CHAN_A_OUT_EN), 32'h0);
    $display("Test timer and mixed done");
    // Edge PWM, period field 1 gives 128 counts
    pwm_run(8'ha8, 8'ha8, 10'd32, 10'd64, 128);
    check(32'(ca), 32'd32);
    check(32'(cb), 32'd64);
    check(32'(cx), 32'd0);
    check(32'(MATCH_FLAGS), 32'h7);
    // Function codes: inactive, active, waveform
    for (int i = 0; i < 3; i++) begin
      fn = 2'(i);
      pwm_run({2'b10, fn, 4'h8}, 8'ha8, 10'd32, 10'd64, 128);
      check(32'(ca), 32'(exp_a[i]));
    end
    // Active low on A, inverted B
    pwm_run(8'ha0, 8'hac, 10'd32, 10'd40, 128);
    check(32'(ca), 32'd96);
    check(32'(cb), 32'd88);
    $display("Test edge PWM done");
    // Centre alignment codes, period 256
    for (int i = 1; i < 4; i++) begin
      pwm_run(8'ha8, {6'h2a, 2'(i)}, 10'd32, 10'd64, 256);
      check(32'(ca), 32'd63);
      check(32'(cb), 32'd127);
    end
    // A sets period, B duty, A pin unused
    pwm_run(8'ha9, 8'ha8, 10'd50, 10'd25, 50);
    check(32'(cb), 32'd25);
    check(32'(CHAN_A_OUT_EN), 32'h0);
    wr(OFS_CTRL0, 32'h01);
    $display("Test centre and period PWM done");
    wrap_up();
  end
endmodule

// file: etcp_chan.sv
`timescale 1ns/1ns
module etcp_chan import etcp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration and events
  input wire etcp_chan_cfg_s cfg,
  input wire logic mode_ok,
  input wire logic preset,
  input wire logic match,
  input wire logic wave_on,
  input wire logic pin_enable,
  // Pin
  output logic pin,
  output logic pin_en
);

  logic level_reg;

  // Pin level before polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else if (mode_ok) begin
      case (cfg.mode)
        MODE_COMPARE: begin
          if (preset) begin
            level_reg <= cfg.out_ctrl;
          end else if (match) begin
            case (cfg.func)
              FUNC_LOW: level_reg <= 1'b0;
              FUNC_HIGH: level_reg <= 1'b1;
              FUNC_TOGGLE: level_reg <= ~level_reg;
              default: level_reg <= level_reg;
            endcase
          end
        end
        MODE_PWM: begin
          case (cfg.func)
            PWM_WAVE: level_reg <= wave_on ? cfg.out_ctrl : ~cfg.out_ctrl;
            PWM_ACTIVE: level_reg <= cfg.out_ctrl;
            default: level_reg <= ~cfg.out_ctrl;
          endcase
        end
        default: level_reg <= level_reg;
      endcase
    end
  end

  // Registered pin and enable
  always_ff @(posedge clk) begin
    if (rst) begin
      pin <= 1'b0;
      pin_en <= 1'b0;
    end else begin
      pin <= level_reg ^ cfg.polarity;
      pin_en <= mode_ok && pin_enable && (cfg.mode == MODE_COMPARE || cfg.mode == MODE_PWM);
    end
  end

endmodule

// file: etcp_counter.sv
`timescale 1ns/1ns
module etcp_counter import etcp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic centre,
  input wire logic [9:0] top,
  // State
  output logic [9:0] count,
  output logic down
);

  // Edge mode wraps at top, centre mode turns round at top and zero
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= CMP_RST;
      down <= 1'b0;
    end else if (restart) begin
      count <= CMP_RST;
      down <= 1'b0;
    end else if (run) begin
      if (!centre) begin
        count <= (count >= top) ? CMP_RST : count + 10'h001;
        down <= 1'b0;
      end else if (!down) begin
        if (count >= top) begin
          down <= 1'b1;
          count <= (top == CMP_RST) ? CMP_RST : count - 10'h001;
        end else begin
          count <= count + 10'h001;
        end
      end else if (count == CMP_RST) begin
        down <= 1'b0;
        count <= (top == CMP_RST) ? CMP_RST : 10'h001;
      end else begin
        count <= count - 10'h001;
      end
    end
  end

endmodule

// file: etcp_pkg.sv
package etcp_pkg;

  // Counter and comparator width
  localparam int unsigned CNT_W = 10;

  // Operating modes in field encoding order
  typedef enum logic [1:0] {MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER} etcp_mode_e;

  // Output function codes, compare mode
  localparam logic [1:0] FUNC_LOW = 2'h1;
  localparam logic [1:0] FUNC_HIGH = 2'h2;
  localparam logic [1:0] FUNC_TOGGLE = 2'h3;
  // Output function codes, PWM mode
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;

  // Alignment codes
  localparam logic [1:0] ALIGN_EDGE = 2'h0;
  localparam logic [1:0] ALIGN_UP = 2'h1;
  localparam logic [1:0] ALIGN_DOWN = 2'h2;

  // Per channel configuration
  typedef struct packed {
    etcp_mode_e mode;
    logic [1:0] func;
    logic out_ctrl;
    logic polarity;
  } etcp_chan_cfg_s;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_A_LO = 8'h10;
  localparam logic [7:0] OFS_A_HI = 8'h14;
  localparam logic [7:0] OFS_B_LO = 8'h18;
  localparam logic [7:0] OFS_B_HI = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;

  // Field positions
  localparam int unsigned MODE_POS = 6;
  localparam int unsigned FUNC_POS = 4;
  localparam int unsigned OC_BIT = 3;
  localparam int unsigned POL_BIT = 2;
  localparam int unsigned DIR_BIT = 1;
  localparam int unsigned CCLR_BIT = 0;
  localparam int unsigned ALIGN_POS = 0;
  localparam int unsigned RUN_BIT = 3;
  localparam int unsigned PSEL_POS = 0;
  localparam int unsigned FLAG_A = 0;
  localparam int unsigned FLAG_B = 1;
  localparam int unsigned FLAG_P = 2;

  // Reset values and write masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [7:0] CTRL1_WMASK = 8'hfd;

  // Period step is 128 counts, full count range otherwise
  localparam int unsigned PERIOD_SHIFT = 7;
  localparam logic [9:0] COUNT_FULL = 10'h3ff;

  // Unpack a control byte into channel configuration
  function automatic etcp_chan_cfg_s chan_cfg(input logic [7:0] b);
    etcp_chan_cfg_s c;
    c.mode = etcp_mode_e'(b[MODE_POS +: 2]);
    c.func = b[FUNC_POS +: 2];
    c.out_ctrl = b[OC_BIT];
    c.polarity = b[POL_BIT];
    return c;
  endfunction

endpackage

// file: etcp_timer.sv
`timescale 1ns/1ns
module etcp_timer import etcp_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Output pins
  output logic CHAN_A_OUT_PIN,
  output logic CHAN_A_OUT_EN,
  output logic [2:0] CHAN_B_OUT_PIN,
  output logic [2:0] CHAN_B_OUT_EN,
  // Flags and interrupt
  output logic [2:0] MATCH_FLAGS,
  output logic IRQ
);

  // Registers
  logic [3:0] ctrl0_reg;
  logic [7:0] ctrl1_reg, ctrl2_reg;
  logic [9:0] cmp_a_reg, cmp_b_reg;
  logic [2:0] stat_reg, stat_next, mask_reg;
  logic run_prev_reg, pready_reg, pslverr_reg, irq_reg;
  logic [31:0] prdata_reg;

  // Decoded state
  etcp_chan_cfg_s cfg_a, cfg_b;
  logic modes_ok, run, run_rise, running, cclr, is_pwm, centre, down;
  logic [1:0] align;
  logic [2:0] period_sel, evts;
  logic [9:0] top, count;
  logic evt_a, evt_b, evt_p, pin_a, pin_b, en_a, en_b;

  // APB strobes
  logic setup, access, wr, rd_mapped;
  logic [31:0] rd_word;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && pready_reg;
  assign wr = access && PWRITE && PSTRB[0];

  // Match qualified by count direction in centre mode
  function automatic logic dir_ok(input logic ctr, input logic [1:0] al, input logic dn);
    logic ok;
    ok = 1'b1;
    if (ctr) begin
      case (al)
        ALIGN_UP: ok = !dn;
        ALIGN_DOWN: ok = dn;
        default: ok = 1'b1;
      endcase
    end
    return ok;
  endfunction

  // Field decode
  assign cfg_a = chan_cfg(ctrl1_reg);
  assign cfg_b = chan_cfg(ctrl2_reg);
  assign cclr = ctrl1_reg[CCLR_BIT];
  assign align = ctrl2_reg[ALIGN_POS +: 2];
  assign period_sel = ctrl0_reg[PSEL_POS +: 3];
  assign modes_ok = (cfg_a.mode == cfg_b.mode);
  assign run = ctrl0_reg[RUN_BIT] && modes_ok;
  assign run_rise = run && !run_prev_reg;
  assign running = run && !run_rise;
  // PWM mode recognised from mode field
  assign is_pwm = (cfg_a.mode == MODE_PWM);
  assign centre = is_pwm && (align != ALIGN_EDGE);

  // Counter top value
  always_comb begin
    top = COUNT_FULL;
    if (cclr) begin
      if (is_pwm && !centre && cmp_a_reg != CMP_RST) begin
        top = cmp_a_reg - 10'h001;
      end else begin
        top = cmp_a_reg;
      end
    end else if (period_sel != 3'h0) begin
      top = 10'({7'h00, period_sel} << PERIOD_SHIFT);
      if (is_pwm && !centre) begin
        top = top - 10'h001;
      end
    end
  end

  // Comparator events
  // Period, A and B match events
  assign evt_a = running && (count == cmp_a_reg) && dir_ok(centre, align, down);
  assign evt_b = running && (count == cmp_b_reg) && dir_ok(centre, align, down);
  assign evt_p = running && !cclr && (count == top);
  assign evts = {evt_p, evt_b, evt_a};

  // Run edge detector
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run;
    end
  end

  etcp_counter u_counter (
    .clk(CLK),
    .rst(SYS_RST),
    .run(running),
    .restart(run_rise),
    .centre(centre),
    .top(top),
    .count(count),
    .down(down)
  );

  // Channel A unused in PWM with clear-select high
  etcp_chan u_chan_a (
    .clk(CLK),
    .rst(SYS_RST),
    .cfg(cfg_a),
    .mode_ok(modes_ok),
    .preset(run_rise),
    .match(evt_a),
    .wave_on(count < cmp_a_reg),
    .pin_enable(!(is_pwm && cclr)),
    .pin(pin_a),
    .pin_en(en_a)
  );

  // Channel B drives all three B pins
  etcp_chan u_chan_b (
    .clk(CLK),
    .rst(SYS_RST),
    .cfg(cfg_b),
    .mode_ok(modes_ok),
    .preset(run_rise),
    .match(evt_b),
    .wave_on(count < cmp_b_reg),
    .pin_enable(1'b1),
    .pin(pin_b),
    .pin_en(en_b)
  );

  assign CHAN_A_OUT_PIN = pin_a;
  assign CHAN_A_OUT_EN = en_a;
  assign CHAN_B_OUT_PIN = {3{pin_b}};
  assign CHAN_B_OUT_EN = {3{en_b}};

  // Control registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl0_reg <= CTRL_RST[3:0];
      ctrl1_reg <= CTRL_RST;
      ctrl2_reg <= CTRL_RST;
    end else if (wr) begin
      if (PADDR == OFS_CTRL0) begin
        ctrl0_reg <= PWDATA[3:0];
      end
      if (PADDR == OFS_CTRL1) begin
        ctrl1_reg <= PWDATA[7:0] & CTRL1_WMASK;
      end
      if (PADDR == OFS_CTRL2) begin
        ctrl2_reg <= PWDATA[7:0];
      end
    end
  end

  // Compare value registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cmp_a_reg <= CMP_RST;
      cmp_b_reg <= CMP_RST;
    end else if (wr) begin
      if (PADDR == OFS_A_LO) begin
        cmp_a_reg[7:0] <= PWDATA[7:0];
      end
      // Top two bits of compare A
      if (PADDR == OFS_A_HI) begin
        cmp_a_reg[9:8] <= PWDATA[1:0];
      end
      // Compare B low and high bytes
      if (PADDR == OFS_B_LO) begin
        cmp_b_reg[7:0] <= PWDATA[7:0];
      end
      if (PADDR == OFS_B_HI) begin
        cmp_b_reg[9:8] <= PWDATA[1:0];
      end
    end
  end

  // Sticky flags, set wins over write-one clear
  always_comb begin
    stat_next = stat_reg;
    if (wr && PADDR == OFS_STAT) begin
      stat_next = stat_reg & ~PWDATA[2:0];
    end
    stat_next = stat_next | evts;
  end

  // Status, mask and interrupt
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_reg <= FLAGS_RST;
      mask_reg <= FLAGS_RST;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr && PADDR == OFS_MASK) begin
        mask_reg <= PWDATA[2:0];
      end
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  assign MATCH_FLAGS = stat_reg;
  assign IRQ = irq_reg;

  // Read multiplexer, unused bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (PADDR)
      OFS_CTRL0: rd_word[3:0] = ctrl0_reg;
      OFS_CTRL1: begin
        rd_word[7:0] = ctrl1_reg;
        rd_word[DIR_BIT] = down;
      end
      OFS_CTRL2: rd_word[7:0] = ctrl2_reg;
      OFS_COUNT: rd_word[9:0] = count;
      OFS_A_LO: rd_word[7:0] = cmp_a_reg[7:0];
      OFS_A_HI: rd_word[1:0] = cmp_a_reg[9:8];
      OFS_B_LO: rd_word[7:0] = cmp_b_reg[7:0];
      OFS_B_HI: rd_word[1:0] = cmp_b_reg[9:8];
      OFS_STAT: rd_word[2:0] = stat_reg;
      OFS_MASK: rd_word[2:0] = mask_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // APB answer, zero wait states
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= !rd_mapped;
        prdata_reg <= PWRITE ? 32'h0000_0000 : rd_word;
      end else if (access) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_mode_mismatch;
    !modes_ok |-> (!evt_a && !evt_b && !evt_p)
      ##1 (!CHAN_A_OUT_EN && CHAN_B_OUT_EN == 3'h0 && $stable(count));
  endproperty
  a_mode_mismatch: assert property (p_mode_mismatch)
    else $error("event, count or pin drive while channel modes differ");
  property p_period_clear;
    running && !is_pwm && !cclr && count == top |=> count == 10'h000 && stat_reg[FLAG_P];
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("period match did not clear counter and flag");
  property p_no_pflag;
    cclr && !is_pwm && !stat_reg[FLAG_P] |=> !stat_reg[FLAG_P];
  endproperty
  a_no_pflag: assert property (p_no_pflag)
    else $error("period flag raised with clear-select high");
  property p_pmatch_pin_hold;
    cfg_a.mode == MODE_COMPARE && modes_ok && evt_p && !evt_a && !run_rise && !wr
      |-> ##2 $stable(CHAN_A_OUT_PIN);
  endproperty
  a_pmatch_pin_hold: assert property (p_pmatch_pin_hold)
    else $error("period match moved channel A pin");
  property p_func_high;
    cfg_a.mode == MODE_COMPARE && modes_ok && evt_a && cfg_a.func == FUNC_HIGH && !wr
      |-> ##2 CHAN_A_OUT_PIN == (1'b1 ^ $past(cfg_a.polarity, 2));
  endproperty
  a_func_high: assert property (p_func_high)
    else $error("match with high function did not raise pin");
  property p_run_preset;
    cfg_b.mode == MODE_COMPARE && run_rise && !wr
      |-> ##2 CHAN_B_OUT_PIN[0] == ($past(cfg_b.out_ctrl, 2) ^ $past(cfg_b.polarity, 2));
  endproperty
  a_run_preset: assert property (p_run_preset)
    else $error("run edge did not preset B pin");
  property p_timer_release;
    cfg_a.mode == MODE_TIMER && modes_ok ##1 cfg_a.mode == MODE_TIMER && modes_ok
      |-> !CHAN_A_OUT_EN && CHAN_B_OUT_EN == 3'h0;
  endproperty
  a_timer_release: assert property (p_timer_release)
    else $error("pins driven in timer mode");
  property p_edge_lead;
    is_pwm && !centre && running && count == top && cfg_b.func == PWM_WAVE
      && cmp_b_reg != 10'h000 && !wr ##1 !wr
      |-> ##2 CHAN_B_OUT_PIN[0] == ($past(cfg_b.out_ctrl, 3) ^ $past(cfg_b.polarity, 3));
  endproperty
  a_edge_lead: assert property (p_edge_lead)
    else $error("edge PWM leading edge missing at counter wrap");
  property p_pwm_bflag;
    is_pwm && evt_b |=> stat_reg[FLAG_B];
  endproperty
  a_pwm_bflag: assert property (p_pwm_bflag)
    else $error("B match flag not raised in PWM mode");
  property p_a_hi_read;
    setup && !PWRITE && PADDR == OFS_A_HI
      |=> PRDATA == {30'h0, $past(cmp_a_reg[9:8])};
  endproperty
  a_a_hi_read: assert property (p_a_hi_read)
    else $error("compare A high byte read wrong");
  property p_b_lo_read;
    setup && !PWRITE && PADDR == OFS_B_LO
      |=> PRDATA == {24'h00_0000, $past(cmp_b_reg[7:0])};
  endproperty
  a_b_lo_read: assert property (p_b_lo_read)
    else $error("compare B low byte read wrong");
  property p_centre_up_only;
    centre && align == ALIGN_UP && down |-> !evt_a && !evt_b;
  endproperty
  a_centre_up_only: assert property (p_centre_up_only)
    else $error("match while counting down with up alignment");

  // Main scenarios
  c_cmp_a: cover property (cfg_a.mode == MODE_COMPARE && evt_a ##2 CHAN_A_OUT_EN);
  c_pwm_b: cover property (is_pwm && evt_b && centre);
  c_irq: cover property (!IRQ ##1 IRQ);

endmodule
